// ---- nvm_access_ctrl.sv ----
// Purpose: Data memory access control: read, erase, write, atomic erase-and-write
// Assumes: I/O strobes and oscTick synchronous to mclk; memory answers reads combinationally
// Notes: Address byte keeps its value through reset; busy operations survive reset
`include "nvm_map.svh"

// Notes on behaviour
// - Data byte is store source and read result
// - Mode code picks atomic, erase or write
// - Mode bits frozen while strobe set
// - Reset clears mode unless busy
// - Ready request needs enable and global flag
// - Ready request is level while idle
// - Master enable self-clears after four cycles
// - Strobe starts only inside armed window
// - Strobe reads busy until time elapses
// - Programming start stalls CPU two cycles
// - Read strobe fetches byte at once
// - Read stalls CPU four cycles
// - Busy refuses reads and address changes
// - Control bits seven, six read zero
// - Three scratch bytes, reset zero
// - Programming timed by oscillator ticks
// - Address undefined until software loads
module nvm_access_ctrl import nvm_pkg::*; #(
  parameter int TICK_W = 16,
  parameter int ATOMIC_TICKS = `NVM_T_ATOMIC_US * `NVM_OSC_KHZ / `NVM_KHZ_PER_MHZ,
  parameter int SPLIT_TICKS = `NVM_T_SPLIT_US * `NVM_OSC_KHZ / `NVM_KHZ_PER_MHZ
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // CPU I/O access
  input wire logic [5:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  // CPU status and control
  input wire logic gieFlag,
  output logic cpuStall,
  output logic irqReq,
  // Timing oscillator
  input wire logic oscTick,
  // Storage array
  output logic [7:0] memAddr,
  output logic [7:0] memWrData,
  output logic memRead,
  output logic memErase,
  output logic memWrite,
  input wire logic [7:0] memRdData
);

  ctrl_s state_q;
  ctrl_s state_d;

  logic ctrlWr;
  logic busy;
  logic startProg;
  logic startRead;
  logic [1:0] modeSel;
  logic progDone;
  logic timerRst;
  logic [TICK_W-1:0] progTicks;
  logic [7:0] scrRd;
  logic scrHit;

  assign ctrlWr = ioWrEn && (ioAddr == `NVM_OFS_CTRL);
  assign busy = (state_q.st == ST_PROG);

  // mode taken from write only when idle
  assign modeSel = (ctrlWr && !busy) ? ioWrData[`NVM_BIT_PM_HI:`NVM_BIT_PM_LO] : state_q.mode;

  assign startProg = !srst && ctrlWr && ioWrData[`NVM_BIT_PE] && state_q.mpe && !busy &&
                     (modeSel != `NVM_MODE_RSVD);

  assign startRead = !srst && ctrlWr && ioWrData[`NVM_BIT_RE] && !busy;

  assign progTicks = (modeSel == `NVM_MODE_ATOMIC) ? TICK_W'(ATOMIC_TICKS) : TICK_W'(SPLIT_TICKS);

  // Timer keeps running through a reset taken mid-operation
  assign timerRst = srst && !busy;

  nvm_prog_timer #(
    .TICK_W(TICK_W)
  ) i_nvm_prog_timer (
    .mclk(mclk),
    .srst(timerRst),
    .oscTick(oscTick),
    .start(startProg),
    .ticks(progTicks),
    .done(progDone)
  );

  nvm_scratch_regs i_nvm_scratch_regs (
    .mclk(mclk),
    .srst(srst),
    .ioAddr(ioAddr),
    .ioWrEn(ioWrEn),
    .ioWrData(ioWrData),
    .rdData(scrRd),
    .hit(scrHit)
  );

  always_comb begin
    state_d = state_q;
    state_d.memRd = 1'b0;
    state_d.rdPend = 1'b0;

    if (state_q.mpeCnt != `NVM_CNT_RST) begin
      state_d.mpeCnt = state_q.mpeCnt - 3'h1;
      if (state_q.mpeCnt == 3'h1) begin
        state_d.mpe = 1'b0;
      end
    end

    if (state_q.stallCnt != `NVM_CNT_RST) begin
      state_d.stallCnt = state_q.stallCnt - 3'h1;
    end

    case (state_q.st)
      ST_IDLE: begin
        if (startProg) begin
          state_d.st = ST_PROG;
          state_d.memEr = (modeSel != `NVM_MODE_WRITE);
          state_d.memWr = (modeSel != `NVM_MODE_ERASE);
        end
      end
      ST_PROG: begin
        if (progDone) begin
          state_d.st = ST_IDLE;
          state_d.memEr = 1'b0;
          state_d.memWr = 1'b0;
        end
      end
      default: begin
        state_d.st = ST_IDLE;
      end
    endcase

    if (ctrlWr) begin
      state_d.mode = modeSel;
      state_d.rdyIe = ioWrData[`NVM_BIT_RIE];
      if (ioWrData[`NVM_BIT_MPE]) begin
        state_d.mpe = 1'b1;
        state_d.mpeCnt = `NVM_MPE_WINDOW;
      end else begin
        state_d.mpe = 1'b0;
        state_d.mpeCnt = `NVM_CNT_RST;
      end
    end

    if (startProg) begin
      state_d.stallCnt = `NVM_PROG_STALL;
    end

    if (startRead) begin
      state_d.memRd = 1'b1;
      state_d.rdPend = 1'b1;
      state_d.stallCnt = `NVM_READ_STALL;
    end

    if (ioWrEn && (ioAddr == `NVM_OFS_DATA)) begin
      state_d.data = ioWrData;
    end
    // fetched byte lands in data byte
    if (state_q.rdPend) begin
      state_d.data = memRdData;
    end

    if (ioWrEn && (ioAddr == `NVM_OFS_ADDRL) && !busy) begin
      state_d.addr = ioWrData;
    end

    // Read data registered; unmapped offsets read zero
    if (ioRdEn) begin
      if (scrHit) begin
        state_d.ioRd = scrRd;
      end else if (ioAddr == `NVM_OFS_CTRL) begin
        state_d.ioRd = {`NVM_CTRL_RSVD, state_q.mode, state_q.rdyIe, state_q.mpe, busy, 1'b0};
      end else if (ioAddr == `NVM_OFS_DATA) begin
        state_d.ioRd = state_q.data;
      end else if (ioAddr == `NVM_OFS_ADDRL) begin
        state_d.ioRd = state_q.addr;
      end else begin
        state_d.ioRd = `NVM_BYTE_RST;
      end
    end

    if (srst) begin
      state_d.mpe = 1'b0;
      state_d.mpeCnt = `NVM_CNT_RST;
      state_d.stallCnt = `NVM_CNT_RST;
      state_d.rdyIe = 1'b0;
      state_d.rdPend = 1'b0;
      state_d.memRd = 1'b0;
      state_d.ioRd = `NVM_BYTE_RST;
      state_d.data = `NVM_BYTE_RST;
      // reset spares a running operation
      // Unknown power-up state falls into the clearing branch
      if (busy) begin
        state_d.data = state_q.data;
      end else begin
        state_d.st = ST_IDLE;
        state_d.mode = `NVM_MODE_ATOMIC;
        state_d.memEr = 1'b0;
        state_d.memWr = 1'b0;
      end
    end

    state_d.stall = (state_d.stallCnt != `NVM_CNT_RST);
    // gated by enable and global flag
    state_d.irq = state_d.rdyIe && gieFlag && (state_d.st == ST_IDLE);
  end

  always_ff @(posedge mclk) begin
    state_q <= state_d;
  end

  assign ioRdData = state_q.ioRd;
  assign cpuStall = state_q.stall;
  assign irqReq = state_q.irq;
  assign memAddr = state_q.addr;
  assign memWrData = state_q.data;
  assign memRead = state_q.memRd;
  assign memErase = state_q.memEr;
  assign memWrite = state_q.memWr;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence mpeArmed;
    $rose(state_q.mpe) ##0 (!ctrlWr)[*4];
  endsequence

  sequence progHalt;
    cpuStall[*2] ##1 !cpuStall;
  endsequence

  sequence readHalt;
    cpuStall[*4] ##1 !cpuStall;
  endsequence

  a_mpe_self_clear: assert property (mpeArmed |=> !state_q.mpe)
    else $error("master enable not cleared after four cycles");

  a_prog_start_busy: assert property (startProg |=> busy && memAddr == $past(state_q.addr))
    else $error("armed strobe did not start programming");

  a_unarmed_ignored: assert property (ctrlWr && ioWrData[`NVM_BIT_PE] && !state_q.mpe && !busy
                                      |=> !busy)
    else $error("strobe without master enable started programming");

  a_prog_stall_two: assert property (startProg |=> progHalt)
    else $error("programming halt is not two cycles");

  a_read_stall_four: assert property (startRead |=> memRead ##0 readHalt)
    else $error("read halt is not four cycles");

  a_read_data_lands: assert property (memRead |=> state_q.data == $past(memRdData))
    else $error("fetched byte not placed in data register");

  a_busy_no_read: assert property (busy && ctrlWr && ioWrData[`NVM_BIT_RE] |=> !memRead)
    else $error("read accepted during programming");

  a_addr_frozen: assert property (busy |=> $stable(state_q.addr))
    else $error("address changed during programming");

  a_mode_frozen: assert property (busy && ctrlWr |=> $stable(state_q.mode))
    else $error("mode bits changed while strobe set");

  a_irq_gated: assert property (irqReq |-> !busy && state_q.rdyIe && $past(gieFlag))
    else $error("ready request without enable or idle");

  // busy ends only on elapsed time
  a_busy_ends_timed: assert property ($fell(busy) |-> $past(progDone))
    else $error("busy cleared before programming time elapsed");

  a_rsvd_inert: assert property (ctrlWr && ioWrData[`NVM_BIT_PE] && state_q.mpe && !busy &&
                                 modeSel == `NVM_MODE_RSVD |=> !busy && !memErase && !memWrite)
    else $error("reserved mode started an operation");

  a_ctrl_top_zero: assert property (ioRdEn && ioAddr == `NVM_OFS_CTRL |=> ioRdData[7:6] == `NVM_CTRL_RSVD)
    else $error("control bits seven and six not zero");

endmodule // nvm_access_ctrl

// ---- nvm_map.svh ----
// Purpose: Offsets, field positions, reset values and timing figures of the nvm access block
// Assumes: 6-bit I/O address space, 8-bit I/O data
// Notes: Definitions only
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// Register offsets
`define NVM_OFS_SCR0 6'h13
`define NVM_OFS_SCR1 6'h14
`define NVM_OFS_SCR2 6'h15
`define NVM_OFS_CTRL 6'h1C
`define NVM_OFS_DATA 6'h1D
`define NVM_OFS_ADDRL 6'h1E
`define NVM_OFS_ADDRH 6'h1F

// Control register fields
`define NVM_BIT_PM_HI 5
`define NVM_BIT_PM_LO 4
`define NVM_BIT_RIE 3
`define NVM_BIT_MPE 2
`define NVM_BIT_PE 1
`define NVM_BIT_RE 0
`define NVM_CTRL_RSVD 2'h0

// Programming modes
`define NVM_MODE_ATOMIC 2'h0
`define NVM_MODE_ERASE 2'h1
`define NVM_MODE_WRITE 2'h2
`define NVM_MODE_RSVD 2'h3

// Reset values
`define NVM_BYTE_RST 8'h00
`define NVM_CNT_RST 3'h0

// Cycle figures
`define NVM_MPE_WINDOW 3'h4
`define NVM_PROG_STALL 3'h2
`define NVM_READ_STALL 3'h4

// Programming times in microseconds and timing oscillator rate in kHz
`define NVM_T_ATOMIC_US 3400
`define NVM_T_SPLIT_US 1800
`define NVM_OSC_KHZ 8000
`define NVM_KHZ_PER_MHZ 1000

`endif

// ---- nvm_pkg.sv ----
// Purpose: Types shared by the nvm access block
// Assumes: nvm_map.svh holds all numbers except the state encodings
// Notes: State of each module is one packed struct
package nvm_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PROG = 2'b10
  } nvm_state_e;

  typedef struct packed {
    nvm_state_e st;
    logic [7:0] addr;
    logic [7:0] data;
    logic [1:0] mode;
    logic rdyIe;
    logic mpe;
    logic [2:0] mpeCnt;
    logic [2:0] stallCnt;
    logic stall;
    logic irq;
    logic rdPend;
    logic memRd;
    logic memEr;
    logic memWr;
    logic [7:0] ioRd;
  } ctrl_s;

  typedef struct packed {
    logic run;
    logic [15:0] cnt;
    logic done;
  } timer_s;

  typedef struct packed {
    logic [2:0][7:0] regs;
  } scratch_s;

endpackage

// ---- nvm_prog_timer.sv ----
// Purpose: Times a programming operation in timing oscillator ticks
// Assumes: oscTick is a one-cycle pulse synchronous to mclk
// Notes: done is a one-cycle pulse after the loaded tick count
`include "nvm_map.svh"

module nvm_prog_timer import nvm_pkg::*; #(
  parameter int TICK_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Control
  input wire logic oscTick,
  input wire logic start,
  input wire logic [TICK_W-1:0] ticks,
  output logic done
);

  timer_s tmr_q;
  timer_s tmr_d;

  always_comb begin
    tmr_d = tmr_q;
    tmr_d.done = 1'b0;
    if (srst) begin
      tmr_d.run = 1'b0;
      tmr_d.cnt = '0;
    end else if (start) begin
      tmr_d.run = 1'b1;
      tmr_d.cnt = ticks;
    end else if (tmr_q.run && oscTick) begin
      // Last tick ends the operation
      if (tmr_q.cnt <= 16'h0001) begin
        tmr_d.run = 1'b0;
        tmr_d.cnt = '0;
        tmr_d.done = 1'b1;
      end else begin
        tmr_d.cnt = tmr_q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    tmr_q <= tmr_d;
  end

  assign done = tmr_q.done;

endmodule // nvm_prog_timer

// ---- nvm_scratch_regs.sv ----
// Purpose: Three general-purpose scratch bytes
// Assumes: Writes are single-cycle strobes
// Notes: Read data is combinational; the parent registers it
`include "nvm_map.svh"

module nvm_scratch_regs import nvm_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // I/O access
  input wire logic [5:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic [7:0] ioWrData,
  output logic [7:0] rdData,
  output logic hit
);

  localparam logic [2:0][5:0] OFS = {`NVM_OFS_SCR2, `NVM_OFS_SCR1, `NVM_OFS_SCR0};

  scratch_s scr_q;
  scratch_s scr_d;
  logic [2:0] sel;
  logic [2:0][7:0] masked;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sel
      assign sel[gi] = (ioAddr == OFS[gi]);
      assign masked[gi] = sel[gi] ? scr_q.regs[gi] : `NVM_BYTE_RST;
    end
  endgenerate

  always_comb begin
    scr_d = scr_q;
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        scr_d.regs[i] = `NVM_BYTE_RST;
      end else if (ioWrEn && sel[i]) begin
        scr_d.regs[i] = ioWrData;
      end
    end
  end

  always_ff @(posedge mclk) begin
    scr_q <= scr_d;
  end

  assign rdData = masked[0] | masked[1] | masked[2];
  assign hit = |sel;

endmodule // nvm_scratch_regs

// ---- nvm_array_model.sv ----
// Purpose: Storage array on the far side
// Assumes: Erase sets bits, write clears
// Notes: Stale read bus shows inverse
module nvm_array_model (
  // Clock
  input wire logic mclk,
  // Array side
  input wire logic [7:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic memRead,
  input wire logic memErase,
  input wire logic memWrite,
  output logic [7:0] memRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] lastQ = 8'h00;
  logic erQ = 1'b0;
  logic wrQ = 1'b0;
  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
  end
  always @(posedge mclk) begin
    erQ <= memErase;
    wrQ <= memWrite;
    if ((erQ | wrQ) & ~(memErase | memWrite)) begin
      mem[memAddr] <= (erQ ? 8'hFF : mem[memAddr]) & (wrQ ? memWrData : 8'hFF);
    end
  end
  always @(posedge mclk) begin
    if (memRead) begin
      lastQ <= mem[memAddr];
    end
  end
  assign memRdData = memRead ? mem[memAddr] : ~lastQ;
endmodule // nvm_array_model

// ---- nvm_access_ctrl_bench.sv ----
// Purpose: Self-checking bench
// Assumes: Short tick counts
// Notes: Inputs change on falling edge
`include "nvm_map.svh"
module nvm_access_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AT = 20;
  localparam int ST = 10;
  localparam logic [5:0] OC = `NVM_OFS_CTRL;
  localparam logic [5:0] OD = `NVM_OFS_DATA;
  localparam logic [5:0] OA = `NVM_OFS_ADDRL;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] ioAddr = 6'h00;
  logic ioWrEn = 1'b0;
  logic ioRdEn = 1'b0;
  logic [7:0] ioWrData = 8'h00;
  logic gieFlag = 1'b0;
  logic oscTick = 1'b0;
  logic [7:0] ioRdData, memAddr, memWrData, memRdData;
  logic cpuStall, irqReq, memRead, memErase, memWrite;
  int failCount = 0;
  int samplesChecked = 0;
  int busyCycles = 0;

  always #5 mclk = ~mclk;
  always @(negedge mclk) oscTick <= ~oscTick;
  always @(posedge mclk) begin
    if (memErase | memWrite) begin
      busyCycles <= busyCycles + 1;
    end
  end

  nvm_access_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) i_nvm_access_ctrl (
    .mclk(mclk), .srst(srst), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .gieFlag(gieFlag), .cpuStall(cpuStall),
    .irqReq(irqReq), .oscTick(oscTick), .memAddr(memAddr), .memWrData(memWrData),
    .memRead(memRead), .memErase(memErase), .memWrite(memWrite), .memRdData(memRdData));
  nvm_array_model i_nvm_array_model (
    .mclk(mclk), .memAddr(memAddr), .memWrData(memWrData), .memRead(memRead),
    .memErase(memErase), .memWrite(memWrite), .memRdData(memRdData));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic io(input logic wr, input logic rd, input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    ioWrEn = wr;
    ioRdEn = rd;
    ioAddr = a;
    ioWrData = d;
  endtask

  task automatic idle(input int n);
    repeat (n) io(1'b0, 1'b0, OC, 8'h00);
  endtask

  task automatic expRd(input logic [5:0] a, input logic [7:0] exp, input string what);
    io(1'b0, 1'b1, a, 8'h00);
    idle(1);
    check(what, ioRdData, exp);
  endtask

  task automatic testDone;
    if (failCount == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic regsTest;
    logic [5:0] ofs [7] = '{6'h13, 6'h14, 6'h15, OC, OD, 6'h1F, 6'h00};
    foreach (ofs[i]) begin
      expRd(ofs[i], 8'h00, "reset value");
    end
    for (int i = 0; i < 3; i++) begin
      io(1'b1, 1'b0, 6'h13 + 6'(i), 8'hA5 ^ 8'(i));
      expRd(6'h13 + 6'(i), 8'hA5 ^ 8'(i), "scratch");
    end
    io(1'b1, 1'b0, OC, 8'hC8);
    expRd(OC, 8'h08, "control top bits");
    io(1'b1, 1'b0, OC, 8'h00);
  endtask

  // Gap is idle cycles between arming and strobe
  task automatic prog(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] exp, input int gap);
    logic go;
    int t;
    go = (m != 2'h3) && (gap < 4);
    t = (m == 2'h0) ? AT : ST;
    io(1'h1, 1'h0, OA, a);
    io(1'h1, 1'h0, OD, d);
    io(1'h1, 1'h0, OC, {2'h0, m, 4'h4});
    idle(gap);
    io(1'h1, 1'h0, OC, {2'h0, m, 4'h2});
    busyCycles = 0;
    for (int i = 0; i < 3; i++) begin
      idle(1);
      check("start stall", 8'(cpuStall), 8'(go && i < 2));
    end
    check("array op", 8'({memErase, memWrite}), go ? 8'(2'h3 - m) : 8'h00);
    check("store data", memWrData, d);
    expRd(OC, {2'h0, m, 2'h0, go, 1'h0}, "busy flag");
    if (go) begin
      io(1'h1, 1'h0, OC, {2'h0, ~m, 4'h3});
      io(1'h1, 1'h0, OA, ~a);
      check("read refused", 8'(memRead), 8'h00);
      expRd(OC, {2'h0, m, 4'h2}, "frozen mode");
      check("frozen address", memAddr, a);
      for (int i = 0; i < 300 && (memErase | memWrite); i++) begin
        idle(1);
      end
      // Tick phase is free, so allow slack
      check("busy length", 8'(busyCycles >= 2 * t - 3 && busyCycles <= 2 * t + 3), 8'h01);
      idle(2);
    end
    expRd(OC, {2'h0, m, 4'h0}, "busy end");
    check("array cell", i_nvm_array_model.mem[a], exp);
  endtask

  task automatic rdMem(input logic [7:0] a, input logic [7:0] exp);
    for (int i = 0; i < 60; i++) begin
      io(1'h0, 1'h1, OC, 8'h00);
      idle(1);
      if (!ioRdData[1]) break;
    end
    check("busy before read", 8'(ioRdData[1]), 8'h00);
    io(1'h1, 1'h0, OA, a);
    io(1'h1, 1'h0, OC, 8'h01);
    for (int i = 0; i < 5; i++) begin
      idle(1);
      check("read stall", 8'(cpuStall), 8'(i < 4));
      check("read pulse", 8'(memRead), 8'(i == 0));
    end
    expRd(OD, exp, "read data");
  endtask

  // Reads land in the last armed cycle and the first disarmed one
  task automatic mpeTest;
    io(1'h1, 1'h0, OC, 8'h04);
    expRd(OC, 8'h04, "armed");
    idle(1);
    io(1'h0, 1'h1, OC, 8'h00);
    io(1'h0, 1'h1, OC, 8'h00);
    check("armed last cycle", ioRdData, 8'h04);
    idle(1);
    check("disarmed", ioRdData, 8'h00);
  endtask

  task automatic irqTest;
    io(1'h1, 1'h0, OC, 8'h08);
    gieFlag = 1'h1;
    for (int i = 0; i < 6; i++) begin
      idle(1);
      if (i > 1) begin
        check("ready level", 8'(irqReq), 8'h01);
      end
    end
    gieFlag = 1'h0;
    idle(2);
    check("global mask", 8'(irqReq), 8'h00);
    gieFlag = 1'h1;
    io(1'h1, 1'h0, OC, 8'h08);
    io(1'h1, 1'h0, OC, 8'h00);
    check("ready again", 8'(irqReq), 8'h01);
    idle(2);
    check("enable mask", 8'(irqReq), 8'h00);
  endtask

  task automatic resetBusy;
    io(1'b1, 1'b0, OC, 8'h1C);
    io(1'b1, 1'b0, OC, 8'h1A);
    idle(3);
    check("ready while busy", 8'(irqReq), 8'h00);
    srst = 1'b1;
    idle(2);
    srst = 1'b0;
    expRd(OC, 8'h12, "mode through reset");
    for (int i = 0; i < 100 && memErase; i++) begin
      idle(1);
    end
    idle(2);
    check("erase after reset", i_nvm_array_model.mem[8'h5A], 8'hFF);
    srst = 1'b1;
    idle(2);
    srst = 1'b0;
    expRd(OC, 8'h00, "mode reset idle");
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    srst = 1'b0;
    regsTest;
    prog(2'd0, 8'h5A, 8'h3C, 8'h3C, 0);
    rdMem(8'h5A, 8'h3C);
    prog(2'd1, 8'h5A, 8'h00, 8'hFF, 3);
    prog(2'd2, 8'h5A, 8'h81, 8'h81, 1);
    prog(2'd3, 8'h5A, 8'h00, 8'h81, 0);
    prog(2'd0, 8'h5A, 8'h11, 8'h81, 4);
    rdMem(8'h5A, 8'h81);
    mpeTest;
    irqTest;
    resetBusy;
    testDone;
  end

  // Tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    failCount++;
    testDone;
  end
endmodule // nvm_access_ctrl_bench
